// File: cap_codec_pkg.sv
// Shared constants and the two-entry symbol buffer for the scrambler and trellis codec.
package cap_codec_pkg;

  // Scrambler shift register length and tap delays.
  localparam int SCR_LEN = 23;
  localparam int TAP_CUSTOMER = 18;
  localparam int TAP_EXCHANGE = 5;
  localparam logic [22:0] SCR_RESET = 23'h000000;

  // Information bits per symbol for each constellation format.
  localparam int BITS_UNCODED64 = 6;
  localparam int BITS_CODED64 = 5;
  localparam int BITS_CODED128 = 6;
  localparam int GROUP_W = 6;
  localparam int LABEL_W = 7;
  localparam int LEVEL_W = 4;

  // Line rates in kbit/s served by each configuration.
  localparam int RATE_TWO_PAIR_KBPS = 1168;
  localparam int RATE_ONE_PAIR_KBPS = 2320;
  localparam int RATE_LEVEL_KBPS = 2048;

  localparam int TRELLIS_STATES = 8;
  localparam logic [2:0] TRELLIS_RESET = 3'h0;

  typedef enum logic [1:0] {
    FMT_UNCODED64 = 2'b00,
    FMT_CODED64 = 2'b01,
    FMT_CODED128 = 2'b11
  } symbol_fmt_e;

  function automatic logic [2:0] group_last(input symbol_fmt_e fmt);
    unique case (fmt)
      FMT_UNCODED64: group_last = 3'(BITS_UNCODED64 - 1);
      FMT_CODED64: group_last = 3'(BITS_CODED64 - 1);
      FMT_CODED128: group_last = 3'(BITS_CODED128 - 1);
      default: group_last = 3'(BITS_UNCODED64 - 1);
    endcase
  endfunction : group_last

  // Feedback of a scrambler register for a given tap delay.
  function automatic logic scr_feedback(input logic [22:0] hist, input int tap);
    scr_feedback = hist[tap - 1] ^ hist[SCR_LEN - 1];
  endfunction : scr_feedback

  // Systematic 8-state encoder next-state table, indexed by {state, second bit, first bit}.
  localparam logic [191:0] TRELLIS_NEXT_TABLE = {
    24'hFAC688, 24'hDE54C1, 24'hB3E21A, 24'h977053,
    24'h688FAC, 24'h4C1DE5, 24'h21AB3E, 24'h053977
  };

  function automatic logic [2:0] trellis_next(input logic [2:0] state, input logic i1, input logic i2);
    logic [5:0] idx;
    idx = {1'b0, state, i2, i1};
    trellis_next = TRELLIS_NEXT_TABLE[idx * 3 +: 3];
  endfunction : trellis_next

  // Label to constellation level table: in-phase from even label bits, quadrature from odd bits.
  function automatic logic [7:0] map_point(input logic [6:0] label);
    map_point = {label[6], label[4], label[2], label[0], 1'b0, label[5], label[3], label[1]};
  endfunction : map_point

endpackage : cap_codec_pkg

`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
  parameter int WIDTH = 15
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] slot0;
  logic [WIDTH-1:0] slot1;
  logic [1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = slot0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= 2'h0;
    end else begin
      count <= count + 2'(push) - 2'(pop);
    end
  end

  // Slot 0 is always the head; slot 1 holds the word that arrives behind it.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slot0 <= '0;
      slot1 <= '0;
    end else begin
      if (pop) begin
        slot0 <= (count == 2'h2) ? slot1 : in_data;
      end else if (push && count == 2'h0) begin
        slot0 <= in_data;
      end
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2))) begin
        slot1 <= in_data;
      end
    end
  end
endmodule : two_entry_buffer

`default_nettype wire

// File: cap_trellis_scrambler_codec.sv
// Scrambler, symbol grouping and trellis coding for the transmit path, and the matching receive path.
// Operation
// - Transmit and receive scramblers use different polynomials, chosen by unit side.
// - Customer side scrambles with taps 18,23; exchange side descrambles with those.
// - Exchange side scrambles with taps 5,23; customer side descrambles with those.
// - Self-synchronising scrambler: output is input xor earlier outputs at the taps.
// - Self-synchronising descrambler: output is input xor earlier received bits at taps.
// - Locked mode xors a free-running sequence on transmit and removes it on receive.
// - Switch to locked mode happens during all-ones data, without end coordination.
// - Every frame bit is scrambled; no field bypasses the scrambler.
// - 1168 kbit/s uses coded 64-point symbols, 2320 kbit/s coded 128-point.
// - Two-pair uses two 1168 kbit/s units; one-pair uses one 2320 kbit/s unit.
// - Eight-state systematic code adds exactly one redundant bit per symbol.
// - Coded 64-point: five bits LSB first, first two encoded, six label bits.
// - Coded 128-point: six bits LSB first, first two encoded, seven label bits.
// - Start-up sends uncoded 64-point symbols, six scrambled bits, LSB first.
`timescale 1ns/1ps
`default_nettype none

module cap_trellis_scrambler_codec
  import cap_codec_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic exchange_side_unit,
  input wire logic one_pair,
  input wire logic startup,
  input wire logic locked,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  output logic tx_bit_ready,
  output logic sym_valid,
  input wire logic sym_ready,
  output logic [LABEL_W-1:0] sym_label,
  output logic [LEVEL_W-1:0] sym_i,
  output logic [LEVEL_W-1:0] sym_q,
  input wire logic [LABEL_W-1:0] rx_label,
  input wire logic rx_label_valid,
  output logic rx_label_ready,
  output logic rx_bit,
  output logic rx_bit_valid,
  input wire logic rx_bit_ready
);
  typedef enum logic {
    TX_FILL = 1'b0,
    TX_PUSH = 1'b1
  } tx_state_e;

  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_SHIFT = 1'b1
  } rx_state_e;

  localparam int BUF_W = LABEL_W + 2 * LEVEL_W;

  symbol_fmt_e fmt;
  tx_state_e tx_state;
  rx_state_e rx_state;
  int tx_tap;
  int rx_tap;
  logic [22:0] tx_hist;
  logic [22:0] rx_hist;
  logic tx_seq;
  logic tx_scr;
  logic tx_take;
  logic [GROUP_W-1:0] tx_group;
  logic [2:0] tx_cnt;
  logic [2:0] trellis_state;
  logic trellis_redundant_bit;
  logic first_info_bit;
  logic second_info_bit;
  logic [LABEL_W-1:0] next_label;
  logic buf_in_ready;
  logic tx_push;
  logic [BUF_W-1:0] buf_out;
  logic [GROUP_W-1:0] rx_info;
  logic [2:0] rx_left;
  logic rx_line_bit;
  logic rx_seq;
  logic rx_step;

  // Start-up forces the uncoded constellation; otherwise the pair count picks the coded size.
  assign fmt = startup ? FMT_UNCODED64 : (one_pair ? FMT_CODED128 : FMT_CODED64);

  // The two directions always use different polynomials.
  assign tx_tap = exchange_side_unit ? TAP_EXCHANGE : TAP_CUSTOMER;
  assign rx_tap = exchange_side_unit ? TAP_CUSTOMER : TAP_EXCHANGE;

  // Transmit scrambler.

  assign tx_bit_ready = (tx_state == TX_FILL);
  assign tx_take = tx_bit_valid && tx_bit_ready;
  assign tx_seq = scr_feedback(tx_hist, tx_tap);
  assign tx_scr = tx_bit ^ tx_seq;

  // In self-synchronising mode the register holds past outputs; when locked it runs on its own
  // feedback, so the sequence continues from whatever start-up left in it.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_hist <= SCR_RESET;
    end else if (tx_take) begin
      tx_hist <= {tx_hist[21:0], locked ? tx_seq : tx_scr};
    end
  end

  // Symbol grouping and trellis coding.

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_state <= TX_FILL;
      tx_cnt <= 3'h0;
      tx_group <= '0;
    end else begin
      unique case (tx_state)
        TX_FILL: begin
          if (tx_take) begin
            tx_group[tx_cnt] <= tx_scr;
            if (tx_cnt >= group_last(fmt)) begin
              tx_cnt <= 3'h0;
              tx_state <= TX_PUSH;
            end else begin
              tx_cnt <= tx_cnt + 3'h1;
            end
          end
        end
        TX_PUSH: begin
          if (tx_push) begin
            tx_group <= '0;
            tx_state <= TX_FILL;
          end
        end
      endcase
    end
  end

  assign first_info_bit = tx_group[0];
  assign second_info_bit = tx_group[1];
  assign trellis_redundant_bit = trellis_state[0];
  assign tx_push = (tx_state == TX_PUSH) && buf_in_ready;

  always_comb begin
    unique case (fmt)
      FMT_UNCODED64: next_label = {1'b0, tx_group};
      FMT_CODED64: next_label = {1'b0, tx_group[4:0], trellis_redundant_bit};
      FMT_CODED128: next_label = {tx_group, trellis_redundant_bit};
      default: next_label = {1'b0, tx_group};
    endcase
  end

  // The encoder only advances on coded symbols, so start-up symbols leave its state unchanged.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trellis_state <= TRELLIS_RESET;
    end else if (tx_push && fmt != FMT_UNCODED64) begin
      trellis_state <= trellis_next(trellis_state, first_info_bit, second_info_bit);
    end
  end

  two_entry_buffer #(
    .WIDTH(BUF_W)
  ) u_sym_buffer (
    .clk(clk),
    .reset(reset),
    .in_valid(tx_state == TX_PUSH),
    .in_ready(buf_in_ready),
    .in_data({map_point(next_label), next_label}),
    .out_valid(sym_valid),
    .out_ready(sym_ready),
    .out_data(buf_out)
  );

  assign sym_label = buf_out[LABEL_W-1:0];
  assign sym_q = buf_out[LABEL_W +: LEVEL_W];
  assign sym_i = buf_out[LABEL_W + LEVEL_W +: LEVEL_W];

  // Receive path.

  // Labels are the decided symbols; the redundant bit is dropped and the rest are sent LSB first.
  assign rx_label_ready = (rx_state == RX_IDLE);
  assign rx_line_bit = rx_info[0];
  assign rx_step = (rx_state == RX_SHIFT) && (!rx_bit_valid || rx_bit_ready);
  assign rx_seq = scr_feedback(rx_hist, rx_tap);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_state <= RX_IDLE;
      rx_info <= '0;
      rx_left <= 3'h0;
    end else begin
      unique case (rx_state)
        RX_IDLE: begin
          if (rx_label_valid) begin
            rx_info <= (fmt == FMT_UNCODED64) ? rx_label[5:0] : rx_label[6:1];
            rx_left <= group_last(fmt);
            rx_state <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (rx_step) begin
            rx_info <= {1'b0, rx_info[GROUP_W-1:1]};
            if (rx_left == 3'h0) begin
              rx_state <= RX_IDLE;
            end else begin
              rx_left <= rx_left - 3'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_hist <= SCR_RESET;
    end else if (rx_step) begin
      rx_hist <= {rx_hist[21:0], locked ? rx_seq : rx_line_bit};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_bit <= 1'b0;
      rx_bit_valid <= 1'b0;
    end else if (rx_step) begin
      rx_bit <= rx_line_bit ^ rx_seq;
      rx_bit_valid <= 1'b1;
    end else if (rx_bit_ready) begin
      rx_bit_valid <= 1'b0;
    end
  end

  // Checks on the transmit path and the self-synchronising descrambler.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_tx_selfsync;
    (tx_take && !locked) |=> tx_hist[0] == $past(tx_bit ^ tx_hist[tx_tap - 1] ^ tx_hist[22]);
  endproperty
  a_tx_selfsync: assert property (p_tx_selfsync) else $error("self-sync scrambler output wrong");

  property p_tx_locked;
    (tx_take && locked) |=> tx_hist[0] == $past(tx_hist[tx_tap - 1] ^ tx_hist[22]);
  endproperty
  a_tx_locked: assert property (p_tx_locked) else $error("locked scrambler did not free-run");

  property p_rx_selfsync;
    (rx_step && !locked) |=> rx_hist[0] == $past(rx_info[0]) && rx_bit == ($past(rx_info[0]) ^ $past(rx_seq));
  endproperty
  a_rx_selfsync: assert property (p_rx_selfsync) else $error("self-sync descrambler wrong");

  property p_taps_differ;
    tx_tap != rx_tap && (exchange_side_unit ? tx_tap == TAP_EXCHANGE : tx_tap == TAP_CUSTOMER);
  endproperty
  a_taps_differ: assert property (p_taps_differ) else $error("direction taps not distinct");

  property p_mode_keeps_reg;
    ($changed(locked) && !tx_take) |=> $stable(tx_hist);
  endproperty
  a_mode_keeps_reg: assert property (p_mode_keeps_reg) else $error("mode change disturbed register");

  property p_coded_label;
    (tx_push && fmt != FMT_UNCODED64) |-> next_label[0] == trellis_state[0]
      && next_label[2:1] == tx_group[1:0] && (fmt == FMT_CODED128 || !next_label[6]);
  endproperty
  a_coded_label: assert property (p_coded_label) else $error("coded label layout wrong");

  property p_uncoded_label;
    (tx_push && fmt == FMT_UNCODED64) |-> next_label == {1'b0, tx_group} ##1 $stable(trellis_state);
  endproperty
  a_uncoded_label: assert property (p_uncoded_label) else $error("uncoded symbol touched trellis");

  property p_group_len;
    (tx_state == TX_FILL) |-> tx_cnt <= group_last(fmt);
  endproperty
  a_group_len: assert property (p_group_len) else $error("group counter overran");

  property p_no_bypass;
    tx_take |=> tx_group[$past(tx_cnt)] == $past(tx_bit ^ tx_seq);
  endproperty
  a_no_bypass: assert property (p_no_bypass) else $error("frame bit not scrambled");

  // A group must close on its last bit, and the encoder may only move when a symbol is pushed into the buffer.
  property p_fmt_select;
    (!startup) |-> (one_pair ? fmt == FMT_CODED128 : fmt == FMT_CODED64);
  endproperty
  a_fmt_select: assert property (p_fmt_select) else $error("coded format not chosen by pair count");

  property p_startup_fmt;
    startup |-> fmt == FMT_UNCODED64;
  endproperty
  a_startup_fmt: assert property (p_startup_fmt) else $error("start-up not uncoded");

  property p_tx_ready_low;
    (tx_take && tx_cnt == group_last(fmt)) |=> !tx_bit_ready;
  endproperty
  a_tx_ready_low: assert property (p_tx_ready_low) else $error("group did not close on last bit");

  property p_push_clears;
    tx_push |=> tx_state == TX_FILL && tx_cnt == 3'h0;
  endproperty
  a_push_clears: assert property (p_push_clears) else $error("next group did not start clean");

  property p_trellis_hold;
    !tx_push |=> $stable(trellis_state);
  endproperty
  a_trellis_hold: assert property (p_trellis_hold) else $error("encoder moved without a symbol");

  property p_sym_stable;
    (sym_valid && !sym_ready) |=> sym_valid && $stable(sym_label) && $stable(sym_i) && $stable(sym_q);
  endproperty
  a_sym_stable: assert property (p_sym_stable) else $error("stalled symbol changed");

  // The descrambler must mirror the transmit side in both modes and keep stalled bits.
  property p_rx_locked;
    (rx_step && locked) |=> rx_hist[0] == $past(rx_seq) && rx_bit == ($past(rx_info[0]) ^ $past(rx_seq));
  endproperty
  a_rx_locked: assert property (p_rx_locked) else $error("locked descrambler wrong");

  property p_rx_mode_keeps_reg;
    ($changed(locked) && !rx_step) |=> $stable(rx_hist);
  endproperty
  a_rx_mode_keeps_reg: assert property (p_rx_mode_keeps_reg) else $error("receive register disturbed");

  property p_rx_bit_hold;
    (rx_bit_valid && !rx_bit_ready) |=> rx_bit_valid && $stable(rx_bit);
  endproperty
  a_rx_bit_hold: assert property (p_rx_bit_hold) else $error("stalled receive bit lost");

  property p_rx_count;
    (rx_state == RX_SHIFT) |-> rx_left <= group_last(fmt);
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("receive bit counter overran");

  property p_uncoded_rx;
    (rx_label_valid && rx_label_ready && fmt == FMT_UNCODED64) |=> rx_info == $past(rx_label[5:0]);
  endproperty
  a_uncoded_rx: assert property (p_uncoded_rx) else $error("uncoded label bits misplaced");

  property p_coded_rx;
    (rx_label_valid && rx_label_ready && fmt != FMT_UNCODED64) |=> rx_info == $past(rx_label[6:1]);
  endproperty
  a_coded_rx: assert property (p_coded_rx) else $error("coded label bits misplaced");

  property p_rx_ready_after;
    (rx_step && rx_left == 3'h0) |=> rx_label_ready;
  endproperty
  a_rx_ready_after: assert property (p_rx_ready_after) else $error("receive did not return to idle");

endmodule : cap_trellis_scrambler_codec

`default_nettype wire

// File: far_side_model.sv
// Far-side modulator model that takes symbols promptly, slowly or not at all.
`timescale 1ns/1ps
`default_nettype none

module far_side_model
  import cap_codec_pkg::*;
(
  input wire logic clk,
  input wire logic hold,
  input wire logic slow,
  input wire logic sym_valid,
  output logic sym_ready,
  input wire logic [LABEL_W-1:0] sym_label,
  input wire logic [LEVEL_W-1:0] sym_i,
  input wire logic [LEVEL_W-1:0] sym_q
);
  logic [14:0] got[$];
  logic phase = 1'b0;

  initial sym_ready = 1'b0;

  // Ready changes just after the edge, so a taken symbol is always judged at a settled edge.
  always @(posedge clk) begin
    if (sym_valid && sym_ready) begin
      got.push_back({sym_label, sym_i, sym_q});
    end
    phase <= ~phase;
    sym_ready <= #1 ~hold & (~slow | phase);
  end
endmodule : far_side_model

`default_nettype wire

// File: cap_trellis_scrambler_codec_tb.sv
// Self-checking testbench for the scrambler and trellis codec.
`timescale 1ns/1ps
`default_nettype none

module cap_trellis_scrambler_codec_tb;
  import cap_codec_pkg::*;
  logic clk = 0, reset = 1, exch = 0, one_pair = 0, startup = 1, locked = 0;
  logic tx_bit = 0, tx_bit_valid = 0, rx_label_valid = 0, rx_bit_ready = 1, hold = 0, slow = 0;
  logic [LABEL_W-1:0] rx_label = '0;
  logic tx_bit_ready, sym_valid, sym_ready, rx_label_ready, rx_bit, rx_bit_valid;
  logic [LABEL_W-1:0] sym_label;
  logic [LEVEL_W-1:0] sym_i, sym_q;
  int bad_count = 0, total_checks = 0;
  logic [22:0] ts, rs;
  logic [2:0] tr;
  logic [6:0] exp_q[$], mask_q[$];
  logic rx_got[$], rx_exp[$];

  always #2.5 clk = ~clk;

  cap_trellis_scrambler_codec DUT (.clk(clk), .reset(reset), .exchange_side_unit(exch), .one_pair(one_pair),
    .startup(startup), .locked(locked), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .tx_bit_ready(tx_bit_ready), .sym_valid(sym_valid), .sym_ready(sym_ready), .sym_label(sym_label),
    .sym_i(sym_i), .sym_q(sym_q), .rx_label(rx_label), .rx_label_valid(rx_label_valid),
    .rx_label_ready(rx_label_ready), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_bit_ready(rx_bit_ready));

  far_side_model far (.clk(clk), .hold(hold), .slow(slow), .sym_valid(sym_valid), .sym_ready(sym_ready),
    .sym_label(sym_label), .sym_i(sym_i), .sym_q(sym_q));

  always @(posedge clk) begin
    if (rx_bit_valid && rx_bit_ready) begin
      rx_got.push_back(rx_bit);
    end
  end

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  // Reference scrambler: locked feeds back its own taps, self-sync shifts in line-side bits.
  task automatic scr(inout logic [22:0] s, input logic b, input int tap, input logic rx, output logic o);
    logic fb;
    fb = s[tap - 1] ^ s[22];
    o = b ^ fb;
    s = {s[21:0], locked ? fb : (rx ? b : o)};
  endtask : scr

  task automatic do_reset(input int n);
    reset = 1;
    repeat (n) @(posedge clk);
    #1;
    reset = 0;
    ts = '0;
    rs = '0;
    tr = TRELLIS_RESET;
    far.got.delete();
  endtask : do_reset

  // Valid stays high between groups; ready low after a last bit keeps stale bits from being taken.
  task automatic send_group(input int n, input logic [5:0] d);
    int w;
    logic o;
    logic [6:0] lab;
    lab = '0;
    for (int i = 0; i < n; i++) begin
      tx_bit = d[i];
      tx_bit_valid = 1;
      w = 0;
      while (tx_bit_ready !== 1'b1 && w < 100) begin
        @(posedge clk);
        #1;
        w++;
      end
      check(w < 100, "transmit bit refused too long");
      @(posedge clk);
      #1;
      scr(ts, d[i], exch ? TAP_EXCHANGE : TAP_CUSTOMER, 1'b0, o);
      lab[startup ? i : i + 1] = o;
    end
    // The reference encoder walks the shared next-state table, so the redundant bit is judged too.
    if (!startup) begin
      lab[0] = tr[0];
      tr = TRELLIS_NEXT_TABLE[{tr, lab[2], lab[1]} * 3 +: 3];
    end
    exp_q.push_back(lab);
    mask_q.push_back(7'h7F);
  endtask : send_group

  task automatic compare_syms();
    logic [14:0] g;
    logic [6:0] l;
    int w;
    w = 0;
    tx_bit_valid = 0;
    while (far.got.size() < exp_q.size() && w < 500) begin
      @(posedge clk);
      #1;
      w++;
    end
    check(far.got.size() == exp_q.size(), "symbol count");
    while (exp_q.size() > 0 && far.got.size() > 0) begin
      g = far.got.pop_front();
      l = g[14:8];
      check(((l ^ exp_q[0]) & mask_q[0]) === 7'h00, "symbol label");
      check(g[7:0] === {l[6], l[4], l[2], l[0], 1'b0, l[5], l[3], l[1]}, "symbol levels");
      void'(exp_q.pop_front());
      void'(mask_q.pop_front());
    end
    exp_q.delete();
    mask_q.delete();
  endtask : compare_syms

  task automatic send_label(input logic [6:0] lab);
    int w;
    logic o;
    w = 0;
    rx_label = lab;
    rx_label_valid = 1;
    while (rx_label_ready !== 1'b1 && w < 100) begin
      @(posedge clk);
      #1;
      w++;
    end
    check(w < 100, "label refused too long");
    @(posedge clk);
    #1;
    for (int i = (startup ? 0 : 1); i <= (startup ? 5 : (one_pair ? 6 : 5)); i++) begin
      scr(rs, lab[i], exch ? TAP_CUSTOMER : TAP_EXCHANGE, 1'b1, o);
      rx_exp.push_back(o);
    end
  endtask : send_label

  task automatic compare_rx();
    int w;
    w = 0;
    rx_label_valid = 0;
    rx_label = ~rx_label;
    while (rx_got.size() < rx_exp.size() && w < 200) begin
      @(posedge clk);
      #1;
      w++;
    end
    check(rx_got.size() == rx_exp.size(), "received bit count");
    while (rx_got.size() > 0 && rx_exp.size() > 0) begin
      check(rx_got.pop_front() === rx_exp.pop_front(), "received bit");
    end
    rx_got.delete();
    rx_exp.delete();
  endtask : compare_rx

  task automatic t_startup_customer();
    exch = 0;
    startup = 1;
    slow = 1;
    do_reset(2);
    send_group(6, 6'h3F);
    send_group(6, 6'h00);
    send_group(6, 6'h15);
    send_group(6, 6'h2A);
    compare_syms();
    slow = 0;
  endtask : t_startup_customer

  // Self-sync state must survive the mode switch, or the locked sequence would stay all zero.
  task automatic t_exchange_lock();
    exch = 1;
    do_reset(2);
    send_group(6, 6'h2D);
    send_group(6, 6'h19);
    send_group(6, 6'h3F);
    send_group(6, 6'h3F);
    locked = 1;
    send_group(6, 6'h3F);
    send_group(6, 6'h00);
    send_group(6, 6'h33);
    compare_syms();
    locked = 0;
  endtask : t_exchange_lock

  task automatic t_coded();
    exch = 0;
    do_reset(2);
    startup = 0;
    one_pair = 0;
    send_group(5, 6'h1F);
    send_group(5, 6'h0A);
    send_group(5, 6'h15);
    compare_syms();
    one_pair = 1;
    send_group(6, 6'h3F);
    send_group(6, 6'h21);
    send_group(6, 6'h1E);
    compare_syms();
    startup = 1;
    one_pair = 0;
  endtask : t_coded

  task automatic t_buffer_full();
    hold = 1;
    do_reset(2);
    fork
      begin
        send_group(6, 6'h11);
        send_group(6, 6'h22);
        send_group(6, 6'h33);
      end
      begin
        repeat (60) @(posedge clk);
        #1;
        check(tx_bit_ready === 1'b0 && sym_valid === 1'b1 && far.got.size() == 0, "full buffer");
        hold = 0;
      end
    join
    compare_syms();
  endtask : t_buffer_full

  task automatic t_receive();
    exch = 0;
    startup = 1;
    do_reset(2);
    send_label(7'h25);
    send_label(7'h1A);
    send_label(7'h3F);
    compare_rx();
    exch = 1;
    startup = 0;
    one_pair = 1;
    do_reset(2);
    send_label(7'h55);
    send_label(7'h2B);
    compare_rx();
    // Locked coded 64-point receive, with the framer stalling the first label's bits.
    one_pair = 0;
    locked = 1;
    rx_bit_ready = 0;
    send_label(7'h3C);
    repeat (4) @(posedge clk);
    #1;
    rx_bit_ready = 1;
    send_label(7'h4B);
    compare_rx();
    locked = 0;
    startup = 1;
    one_pair = 0;
  endtask : t_receive

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  initial begin
    do_reset(16);
    check(tx_bit_ready === 1'b1 && sym_valid === 1'b0 && sym_label === 7'h00, "transmit reset");
    check(rx_label_ready === 1'b1 && rx_bit_valid === 1'b0 && rx_bit === 1'b0, "receive reset");
    t_startup_customer();
    t_exchange_lock();
    t_coded();
    t_buffer_full();
    t_receive();
    results();
  end

  initial begin
    #100000;
    bad_count++;
    results();
  end
endmodule : cap_trellis_scrambler_codec_tb

`default_nettype wire
